// ==== dv/tb.sv ====
`timescale 1ns/10ps
module tb
  import uvp_pkg::*;
;
  logic                              clk = 1'b0;
  logic                              nrst = 1'b0;
  logic [VW-1:0]                     lo = 12'h3E8;
  logic [VW-1:0]                     hi = 12'h3E8;
  logic [VW-1:0]                     v_ab, v_bc, v_ca;
  logic [GW-1:0]                     group_sel = 2'h0;
  logic [NSTG-1:0]                   ext_block = 3'h0;
  logic [NSTG-1:0]                   start, trip, self_blocked, es, eb;
  logic [NSTG-1:0][NGRP-1:0][PW-1:0] start_pct, block_pct;
  logic [NSTG-1:0][NGRP-1:0][HW-1:0] hyst_pm;
  logic [NSTG-1:0][NGRP-1:0][DW-1:0] op_delay;
  logic [NGRP-1:0][DW-1:0]           release_delay;
  int                                errors, checked, lh, lr, lm, lt, st[NSTG], blk[NSTG];

  always #10 clk = ~clk;

  uvp_src src (.clk(clk), .lo(lo), .hi(hi), .v_ab(v_ab), .v_bc(v_bc), .v_ca(v_ca));

  uvp_stages #(.TICK_CYC(4)) uut (
    .clk(clk), .nrst(nrst), .v_ab(v_ab), .v_bc(v_bc), .v_ca(v_ca), .group_sel(group_sel),
    .ext_block(ext_block), .start_pct(start_pct), .hyst_pm(hyst_pm), .block_pct(block_pct),
    .op_delay(op_delay), .release_delay(release_delay), .start(start), .trip(trip),
    .self_blocked(self_blocked)
  );

  task automatic chk(input string name, input logic [NSTG-1:0] exp, input logic [NSTG-1:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ********
  // reference model: levels held, then outputs compared
  // ********
  task automatic step(input int l, input int h, input logic [NSTG-1:0] e, input int n);
    int thr;
    int lim;
    int g;
    g = group_sel;
    lo = VW'(l);
    hi = VW'(h);
    ext_block = e;
    for (int s = 0; s < NSTG; s++) begin
      thr = start_pct[s][g] * 10;
      lim = block_pct[s][g] * 10;
      if (lim == 0) blk[s] = 0;
      else if (h < lim) blk[s] = 1;
      else if (h * 100 > lim * 103 && h > lim + 5) blk[s] = 0;
      if (blk[s] != 0 || e[s]) st[s] = 0;
      else if (l < thr) st[s] = 1;
      else if (l * 1000 > thr * (1000 + hyst_pm[s][g])) st[s] = 0;
      es[s] = (st[s] != 0);
      eb[s] = (blk[s] != 0);
    end
    repeat (n) @(posedge clk);
    #2;
    chk("start", es, start);
    chk("self_blocked", eb, self_blocked);
  endtask

  // hang guard, far beyond the few thousand cycles needed
  initial begin
    #400000;
    errors++;
    end_sim();
  end

  initial begin
    void'($urandom(32'h2806));
    for (int s = 0; s < NSTG; s++) begin
      for (int g = 0; g < NGRP; g++) begin
        start_pct[s][g] = PW'(50 + $urandom % 41);
        hyst_pm[s][g] = HW'(1 + $urandom % 50);
        // limit kept at 15 % or more on the first two stages so the 10 % level blocks; the third is off
        block_pct[s][g] = (s == 2) ? LIM_OFF : PW'(15 + $urandom % 16);
        op_delay[s][g] = DW'(OP_MIN_MS[s] / TICK_MS);
        release_delay[g] = REL_MIN_TICKS;
      end
    end
    repeat (6) @(posedge clk);
    #2;
    nrst = 1'b1;
    @(posedge clk);
    #2;
    for (int g = 0; g < NGRP; g++) begin
      group_sel = GW'(g);
      lh = 1200;
      lr = 0;
      lm = 0;
      for (int s = 0; s < NSTG; s++) begin
        if (start_pct[s][g] * 10 < lh) lh = start_pct[s][g] * 10;
        lt = start_pct[s][g] * (1000 + hyst_pm[s][g]) / 100 + 1;
        if (lt > lr) lr = lt;
        if (block_pct[s][g] * 10 > lm) lm = block_pct[s][g] * 10;
      end
      step(1000, 1000, 3'b000, 80);
      chk("trip", es, trip);
      step(400, 1000, 3'b000, 5);
      chk("trip", 3'b000, trip);
      step(400, 1000, 3'b000, 80);
      chk("trip", es, trip);
      step(lh, 1000, 3'b000, 5);
      step(lr, 1000, 3'b000, 5);
      chk("trip", 3'b001, trip);
      step(lr, 1000, 3'b000, 80);
      chk("trip", es, trip);
      step(400, 1000, 3'b101, 80);
      chk("trip", es, trip);
      step(400, 1000, 3'b000, 80);
      chk("trip", es, trip);
      step(100, 100, 3'b000, 80);
      chk("trip", es, trip);
      step(100, lm + 5, 3'b000, 80);
      step(100, 1000, 3'b000, 80);
      chk("trip", es, trip);
    end
    end_sim();
  end
endmodule

// ==== dv/uvp_src.sv ====
`timescale 1ns/10ps
module uvp_src
  import uvp_pkg::*;
(
  input  wire logic          clk,
  input  wire logic [VW-1:0] lo,
  input  wire logic [VW-1:0] hi,
  output logic      [VW-1:0] v_ab,
  output logic      [VW-1:0] v_bc,
  output logic      [VW-1:0] v_ca
);
  logic [VW-1:0] lo_q;
  logic [VW-1:0] hi_q;

  // one new sample per clock, one cycle behind the request
  // request captured on the edge, away from the bench's own update time
  initial begin
    v_ab = 12'h3E8;
    v_bc = 12'h3E8;
    v_ca = 12'h3E8;
    forever begin
      @(posedge clk);
      lo_q = lo;
      hi_q = hi;
      #2;
      v_ab <= hi_q;
      v_bc <= lo_q;
      v_ca <= lo_q;
    end
  end
endmodule

// ==== pkg/uvp_pkg.sv ====
// Functional notes
// - stage starts while smallest line voltage is under its start threshold
// - stage trips after start persists longer than the operate delay
// - external block input suppresses start and trip while high
// - stage self-blocked while largest line voltage is under block limit
// - block limit of zero disables self-blocking
// - three independent stages with fixed delay characteristic
// - four setting groups per stage; active group selects settings
// - start threshold 20 to 120 percent in 1 percent steps
// - operate delay up to 300 s; minimum 0.08, 0.06, 0.04 s
// - start releases only above threshold times reset ratio 1.001 to 1.200
// - block limit 0 to 80 percent of nominal
// - stage one release delay 0.06 to 300 s in 0.02 s steps
// - smallest delay setting gives the stage minimum of 0.08, 0.06 or 0.04 s, not instantaneous operation
package uvp_pkg;

  // ****************************************
  // widths and counts
  // ****************************************
  localparam int NSTG = 3;
  localparam int NGRP = 4;
  localparam int GW   = 2;
  localparam int VW   = 12;  // voltage in 0.1 % of nominal
  localparam int PW   = 7;   // percent settings
  localparam int HW   = 8;   // hysteresis in 0.1 %
  localparam int DW   = 15;  // delays in ticks
  localparam int MW   = 24;  // product width

  // ****************************************
  // setting ranges and scaling
  // ****************************************
  localparam logic [PW-1:0] THR_MIN_PCT   = 7'h14;
  localparam logic [PW-1:0] THR_MAX_PCT   = 7'h78;
  localparam logic [PW-1:0] LIM_MAX_PCT   = 7'h50;
  localparam logic [PW-1:0] LIM_OFF       = 7'h00;
  localparam logic [10:0]   PCT_SCALE     = 11'h00A;
  localparam logic [HW-1:0] HYST_MIN      = 8'h01;
  localparam logic [HW-1:0] HYST_MAX      = 8'hC8;
  localparam logic [MW-1:0] HYST_DEN      = 24'h0003E8;
  localparam logic [MW-1:0] BLK_RATIO_NUM = 24'h000067;
  localparam logic [MW-1:0] BLK_RATIO_DEN = 24'h000064;
  localparam logic [VW-1:0] BLK_MARGIN    = 12'h005;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ      = 50000000;
  localparam int TICK_MS     = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int DLY_MAX_MS  = 300000;
  localparam int REL_MIN_MS  = 60;
  localparam int OP_MIN_MS  [NSTG] = '{80, 60, 40};
  localparam int OP_STEP_MS [NSTG] = '{20, 20, 10};
  localparam int REL_STEP_MS = 20;
  localparam logic [DW-1:0] DLY_MAX_TICKS = DW'(DLY_MAX_MS / TICK_MS);
  localparam logic [DW-1:0] REL_MIN_TICKS = DW'((REL_MIN_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [DW-1:0] REL_STEP_TICKS = DW'(REL_STEP_MS / TICK_MS);
  localparam logic [DW-1:0] ZERO_TICKS    = 15'h0000;

endpackage

// ==== src/uvp_stages.sv ====
`timescale 1ns/10ps
module uvp_stages
  import uvp_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input  wire logic                                 clk,
  input  wire logic                                 nrst,
  input  wire logic [VW-1:0]                        v_ab,
  input  wire logic [VW-1:0]                        v_bc,
  input  wire logic [VW-1:0]                        v_ca,
  input  wire logic [GW-1:0]                        group_sel,
  input  wire logic [NSTG-1:0]                      ext_block,
  input  wire logic [NSTG-1:0][NGRP-1:0][PW-1:0]    start_pct,
  input  wire logic [NSTG-1:0][NGRP-1:0][HW-1:0]    hyst_pm,
  input  wire logic [NSTG-1:0][NGRP-1:0][PW-1:0]    block_pct,
  input  wire logic [NSTG-1:0][NGRP-1:0][DW-1:0]    op_delay,
  input  wire logic [NGRP-1:0][DW-1:0]              release_delay,
  output logic      [NSTG-1:0]                      start,
  output logic      [NSTG-1:0]                      trip,
  output logic      [NSTG-1:0]                      self_blocked
);

  // ****************************************
  // tick divider
  // ****************************************
  logic [19:0] tick_cnt;
  logic        tick;
  // registered pulse: all three stages step their timers on the same edge

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt <= 20'h00000;
      tick     <= 1'b0;
    end else if (tick_cnt >= 20'(TICK_CYC - 1)) begin
      tick_cnt <= 20'h00000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 20'h00001;
      tick     <= 1'b0;
    end
  end

  // ****************************************
  // smallest and largest line voltage
  // ****************************************
  logic [VW-1:0] smallest_line_voltage;
  logic [VW-1:0] largest_line_voltage;
  logic [VW-1:0] next_min;
  logic [VW-1:0] next_max;

  always_comb begin
    next_min = (v_ab < v_bc) ? v_ab : v_bc;
    next_min = (v_ca < next_min) ? v_ca : next_min;
    next_max = (v_ab > v_bc) ? v_ab : v_bc;
    next_max = (v_ca > next_max) ? v_ca : next_max;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // full scale until the first sample lands, so reset cannot fake an undervoltage or a self-block
      smallest_line_voltage <= '1;
      largest_line_voltage  <= '1;
    end else begin
      smallest_line_voltage <= next_min;
      largest_line_voltage  <= next_max;
    end
  end

  // ****************************************
  // stage-one release delay, active group
  // ****************************************
  logic [DW-1:0] rel_raw;
  logic [DW-1:0] eff_rel;

  always_comb begin
    rel_raw = release_delay[group_sel];
    // clamp before rounding so an odd full-scale value cannot wrap to zero
    if (rel_raw > DLY_MAX_TICKS) begin
      rel_raw = DLY_MAX_TICKS;
    end else if (rel_raw[0]) begin
      rel_raw = rel_raw + REL_STEP_TICKS - 15'h0001;
    end
    if (rel_raw < REL_MIN_TICKS) begin
      eff_rel = REL_MIN_TICKS;
    end else begin
      eff_rel = rel_raw;
    end
  end

  // ****************************************
  // per-stage logic
  // ****************************************
  logic [DW-1:0] op_cnt   [NSTG];
  logic [DW-1:0] rel_cnt  [NSTG];
  logic [DW-1:0] eff_op   [NSTG];
  logic [VW-1:0] thr_v    [NSTG];
  logic [VW-1:0] lim_v    [NSTG];
  logic          next_blk [NSTG];
  logic          next_st  [NSTG];
  logic          inh      [NSTG];
  logic          under    [NSTG];
  logic          held     [NSTG];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  genvar s;
  generate
    for (s = 0; s < NSTG; s++) begin : g_stage
      localparam logic [DW-1:0] OP_MIN  = DW'((OP_MIN_MS[s] + TICK_MS - 1) / TICK_MS);
      localparam logic [DW-1:0] OP_STEP = DW'(OP_STEP_MS[s] / TICK_MS);
      logic [PW-1:0] thr_pct;
      logic [PW-1:0] lim_pct;
      logic [HW-1:0] hyst;
      logic [DW-1:0] op_raw;
      logic [MW-1:0] thr_prod;
      logic [MW-1:0] min_prod;
      logic [MW-1:0] max_prod;
      logic [MW-1:0] lim_prod;

      always_comb begin
        thr_pct = start_pct[s][group_sel];
        lim_pct = block_pct[s][group_sel];
        hyst    = hyst_pm[s][group_sel];
        op_raw  = op_delay[s][group_sel];
        if (thr_pct < THR_MIN_PCT) begin
          thr_pct = THR_MIN_PCT;
        end else if (thr_pct > THR_MAX_PCT) begin
          thr_pct = THR_MAX_PCT;
        end
        if (lim_pct > LIM_MAX_PCT) begin
          lim_pct = LIM_MAX_PCT;
        end
        if (hyst < HYST_MIN) begin
          hyst = HYST_MIN;
        end else if (hyst > HYST_MAX) begin
          hyst = HYST_MAX;
        end
        if (op_raw > DLY_MAX_TICKS) begin
          op_raw = DLY_MAX_TICKS;
        end else if (OP_STEP > 15'h0001 && op_raw[0]) begin
          op_raw = op_raw + OP_STEP - 15'h0001;
        end
        if (op_raw < OP_MIN) begin
          eff_op[s] = OP_MIN;
        end else begin
          eff_op[s] = op_raw;
        end
        thr_v[s] = VW'(11'(thr_pct) * PCT_SCALE);
        lim_v[s] = VW'(11'(lim_pct) * PCT_SCALE);
        thr_prod = MW'(thr_v[s]) * (HYST_DEN + MW'(hyst));
        min_prod = MW'(smallest_line_voltage) * HYST_DEN;
        max_prod = MW'(largest_line_voltage) * BLK_RATIO_DEN;
        lim_prod = MW'(lim_v[s]) * BLK_RATIO_NUM;
      end

      // self-block with release margin
      always_comb begin
        if (lim_pct == LIM_OFF) begin
          next_blk[s] = 1'b0;
        end else if (largest_line_voltage < lim_v[s]) begin
          next_blk[s] = 1'b1;
        end else if (self_blocked[s] && max_prod > lim_prod &&
                     largest_line_voltage > lim_v[s] + BLK_MARGIN) begin
          next_blk[s] = 1'b0;
        end else begin
          next_blk[s] = self_blocked[s];
        end
        inh[s]     = ext_block[s] | next_blk[s];
        under[s]   = smallest_line_voltage < thr_v[s];
        held[s]    = start[s] && !(min_prod > thr_prod);
        next_st[s] = !inh[s] && (under[s] || held[s]);
      end

      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          self_blocked[s] <= 1'b0;
        end else begin
          self_blocked[s] <= next_blk[s];
        end
      end

      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          start[s] <= 1'b0;
        end else begin
          start[s] <= next_st[s];
        end
      end

      // operate timer
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          op_cnt[s] <= ZERO_TICKS;
        end else if (!next_st[s]) begin
          op_cnt[s] <= ZERO_TICKS;
        end else if (tick && op_cnt[s] < eff_op[s]) begin
          op_cnt[s] <= op_cnt[s] + 15'h0001;
        end
      end

      // only stage one holds its trip after the start releases
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          rel_cnt[s] <= ZERO_TICKS;
        end else if (s != 0 || start[s] || !trip[s]) begin
          rel_cnt[s] <= ZERO_TICKS;
        end else if (tick && rel_cnt[s] < eff_rel) begin
          rel_cnt[s] <= rel_cnt[s] + 15'h0001;
        end
      end

      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          trip[s] <= 1'b0;
        end else if (inh[s]) begin
          trip[s] <= 1'b0;
        end else if (start[s] && next_st[s] && op_cnt[s] >= eff_op[s]) begin
          trip[s] <= 1'b1;
        end else if (!start[s] && (s != 0 || rel_cnt[s] >= eff_rel)) begin
          trip[s] <= 1'b0;
        end
      end

      // ****************************************
      // checks
      // ****************************************
      sequence s_under;
        !inh[s] && under[s];
      endsequence

      sequence s_trip_cause;
        start[s] && op_cnt[s] >= eff_op[s] && !inh[s];
      endsequence

      property p_start_set;
        s_under |=> start[s];
      endproperty
      a_start_set: assert property (p_start_set) else $error("start missing under threshold");

      property p_trip_cause;
        $rose(trip[s]) |-> $past(start[s]) && $past(op_cnt[s]) >= $past(eff_op[s]);
      endproperty
      a_trip_cause: assert property (p_trip_cause) else $error("trip before delay");

      property p_trip_set;
        s_trip_cause ##0 next_st[s] |=> trip[s];
      endproperty
      a_trip_set: assert property (p_trip_set) else $error("trip late");

      property p_ext_block;
        ext_block[s] |=> !start[s] && !trip[s];
      endproperty
      a_ext_block: assert property (p_ext_block) else $error("block ignored");

      property p_self_block;
        (lim_v[s] != '0 && largest_line_voltage < lim_v[s]) |=> self_blocked[s] && !start[s] && !trip[s];
      endproperty
      a_self_block: assert property (p_self_block) else $error("self block ignored");

      property p_block_off;
        (block_pct[s][group_sel] == LIM_OFF) |=> !self_blocked[s];
      endproperty
      a_block_off: assert property (p_block_off) else $error("disabled block active");

      property p_hold;
        start[s] && !inh[s] && !(min_prod > thr_prod) |=> start[s];
      endproperty
      a_hold: assert property (p_hold) else $error("start released inside hysteresis");

      property p_timer_clear;
        !start[s] |-> op_cnt[s] == ZERO_TICKS;
      endproperty
      a_timer_clear: assert property (p_timer_clear) else $error("timer not cleared");

      property p_min_delay;
        eff_op[s] >= OP_MIN && eff_op[s] <= DLY_MAX_TICKS;
      endproperty
      a_min_delay: assert property (p_min_delay) else $error("delay out of range");

      property p_trip_drop;
        (s != 0) && !start[s] |=> !trip[s];
      endproperty
      a_trip_drop: assert property (p_trip_drop) else $error("trip without start");

      property p_rel_hold;
        (s == 0) && trip[s] && !start[s] && !inh[s] && rel_cnt[s] < eff_rel |=> trip[s];
      endproperty
      a_rel_hold: assert property (p_rel_hold) else $error("trip released before release delay");

      property p_rel_drop;
        trip[s] && !start[s] && rel_cnt[s] >= eff_rel |=> !trip[s];
      endproperty
      a_rel_drop: assert property (p_rel_drop) else $error("trip kept after release delay");

      property p_block_clear;
        inh[s] |=> op_cnt[s] == ZERO_TICKS && !start[s];
      endproperty
      a_block_clear: assert property (p_block_clear) else $error("timer kept while blocked");
    end
  endgenerate

endmodule
